// ===== bench/cal_reg_bank_chk.sv
// Port checker for the calibration register bank
`timescale 1ns/1ps
module cal_reg_bank_chk
   import cal_regs_pkg::*;
#(
   parameter int INPUT_COUNT = 10
)
(
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        SRST,
   // Register port
   input wire logic [7:0]  REG_ADDR,
   input wire logic [7:0]  REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [7:0]  REG_RDATA,
   // Sample path
   input wire logic        RAW_VALID,
   input wire logic [23:0] RAW_DATA,
   input wire logic        CAL_VALID,
   input wire logic [23:0] CAL_DATA,
   // Reference and routing
   input wire logic        INTERNAL_REF_ON,
   input wire logic [1:0]  REF_POS_SELECT,
   input wire logic [1:0]  REF_NEG_SELECT,
   input wire logic [9:0]  SRC1_INPUT_SEL,
   input wire logic        SRC1_COMMON_SEL,
   input wire logic [9:0]  SRC2_INPUT_SEL,
   input wire logic        SRC2_COMMON_SEL
);
   default clocking dck @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);

   rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
      else $error("read data not idle");
   ref_rsvd_a: assert property (REG_RD && REG_ADDR == 8'h06 |=> REG_RDATA[7:5] == 3'h0)
      else $error("reserved reference bits read nonzero");
   ref_on_a: assert property (REG_WR && REG_ADDR == 8'h06 |-> ##2 INTERNAL_REF_ON == $past(REG_WDATA[4], 2))
      else $error("reference enable mismatch");
   ref_sel_a: assert property (REG_WR && REG_ADDR == 8'h06 |->
      ##2 {REF_POS_SELECT, REF_NEG_SELECT} == $past(REG_WDATA[3:0], 2))
      else $error("reference selector mismatch");
   src_onehot_a: assert property ($onehot0({SRC1_INPUT_SEL, SRC1_COMMON_SEL})
      && $onehot0({SRC2_INPUT_SEL, SRC2_COMMON_SEL}))
      else $error("current source on several pins");
   src_common_a: assert property (REG_WR && REG_ADDR == 8'h0D && REG_WDATA[3:0] == 4'hA |-> ##2 SRC1_COMMON_SEL)
      else $error("first source not on common");
   src_open_a: assert property (REG_WR && REG_ADDR == 8'h0D && REG_WDATA[7:4] > 4'hA |->
      ##2 !SRC2_COMMON_SEL && SRC2_INPUT_SEL == 10'h000)
      else $error("second source not open");
   cal_lat_a: assert property (RAW_VALID |-> ##3 CAL_VALID)
      else $error("corrected sample late");
   cal_only_a: assert property (CAL_VALID |-> $past(RAW_VALID, 3))
      else $error("corrected sample without raw");
endmodule

bind cal_reg_bank cal_reg_bank_chk #(.INPUT_COUNT(INPUT_COUNT)) i_cal_reg_bank_chk (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RAW_VALID(RAW_VALID),
   .RAW_DATA(RAW_DATA), .CAL_VALID(CAL_VALID), .CAL_DATA(CAL_DATA),
   .INTERNAL_REF_ON(INTERNAL_REF_ON), .REF_POS_SELECT(REF_POS_SELECT),
   .REF_NEG_SELECT(REF_NEG_SELECT), .SRC1_INPUT_SEL(SRC1_INPUT_SEL),
   .SRC1_COMMON_SEL(SRC1_COMMON_SEL), .SRC2_INPUT_SEL(SRC2_INPUT_SEL),
   .SRC2_COMMON_SEL(SRC2_COMMON_SEL));

// ===== bench/cal_reg_bank_test.sv
// Testbench for the calibration register bank
`timescale 1ns/1ps
module cal_reg_bank_test;
   logic        CLK_SYS = 1'b0;
   logic        SRST = 1'b1;
   logic [7:0]  REG_ADDR = 8'h00;
   logic [7:0]  REG_WDATA = 8'h00;
   logic        REG_WR = 1'b0;
   logic        REG_RD = 1'b0;
   logic        RAW_VALID = 1'b0;
   logic [23:0] RAW_DATA = 24'h000000;
   logic [7:0]  REG_RDATA;
   logic        CAL_VALID, INTERNAL_REF_ON, SRC1_COMMON_SEL, SRC2_COMMON_SEL;
   logic [23:0] CAL_DATA;
   logic [1:0]  REF_POS_SELECT, REF_NEG_SELECT;
   logic [9:0]  SRC1_INPUT_SEL, SRC2_INPUT_SEL;
   int          error_cnt = 0;
   int          n_tests = 0;
   int          cycles = 0;
   logic [23:0] ofs, gn;
   logic [23:0] exp_q[$];

   cal_reg_bank #(.INPUT_COUNT(10)) i_cal_reg_bank (
      .CLK_SYS(CLK_SYS), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RAW_VALID(RAW_VALID),
      .RAW_DATA(RAW_DATA), .CAL_VALID(CAL_VALID), .CAL_DATA(CAL_DATA),
      .INTERNAL_REF_ON(INTERNAL_REF_ON), .REF_POS_SELECT(REF_POS_SELECT),
      .REF_NEG_SELECT(REF_NEG_SELECT), .SRC1_INPUT_SEL(SRC1_INPUT_SEL),
      .SRC1_COMMON_SEL(SRC1_COMMON_SEL), .SRC2_INPUT_SEL(SRC2_INPUT_SEL),
      .SRC2_COMMON_SEL(SRC2_COMMON_SEL));

   initial begin
      forever #25 CLK_SYS = ~CLK_SYS;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d errors=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      REG_WR <= 1'b1;
      REG_RD <= 1'b0;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK_SYS);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      REG_RD <= 1'b1;
      REG_WR <= 1'b0;
      REG_ADDR <= a;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      #1;
      chk({16'h0000, REG_RDATA}, {16'h0000, e});
      @(posedge CLK_SYS);
   endtask

   function automatic logic [10:0] route_exp(input logic [3:0] c);
      return (c <= 4'h9) ? (11'h001 << c) : (c == 4'hA) ? 11'h400 : 11'h000;
   endfunction

   function automatic logic [23:0] model(input logic [23:0] x);
      longint d;
      d = (longint'($signed(x)) - longint'($signed(ofs))) * longint'(gn);
      d = d >>> 22;
      if (d > 8388607) begin
         return 24'h7FFFFF;
      end
      if (d < -8388608) begin
         return 24'h800000;
      end
      return d[23:0];
   endfunction

   always @(posedge CLK_SYS) begin
      #1;
      if (CAL_VALID === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(24'h000001, 24'h000000);
         end else begin
            chk(CAL_DATA, exp_q.pop_front());
         end
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [7:0] rv [8] = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'hFF};
      for (int k = 0; k < 8; k++) begin
         rd(8'h06 + 8'(k), rv[k]);
      end
      chk({19'h0, INTERNAL_REF_ON, REF_POS_SELECT, REF_NEG_SELECT}, 24'h000005);
      chk({SRC2_COMMON_SEL, SRC2_INPUT_SEL, SRC1_COMMON_SEL, SRC1_INPUT_SEL}, 24'h000000);
   endtask

   task automatic t_neighbours();
      wr(8'h05, 8'hAA);
      wr(8'h0E, 8'hAA);
      rd(8'h05, 8'h00);
      rd(8'h0E, 8'h00);
      rd(8'h06, 8'h05);
      rd(8'h0D, 8'hFF);
   endtask

   task automatic t_ref();
      for (int i = 0; i < 32; i++) begin
         wr(8'h06, 8'hE0 | 8'(i));
         rd(8'h06, 8'(i));
         chk({19'h0, INTERNAL_REF_ON, REF_POS_SELECT, REF_NEG_SELECT}, 24'(i));
      end
   endtask

   task automatic t_route();
      logic [3:0] c;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         wr(8'h0D, {~c, c});
         rd(8'h0D, {~c, c});
         chk({13'h0, SRC1_COMMON_SEL, SRC1_INPUT_SEL}, {13'h0, route_exp(c)});
         chk({13'h0, SRC2_COMMON_SEL, SRC2_INPUT_SEL}, {13'h0, route_exp(~c)});
      end
   endtask

   task automatic t_cal();
      logic [23:0] tv [6][3] = '{'{24'h000000, 24'h400000, 24'h01E240},
         '{24'hFFFFFB, 24'h400000, 24'h00000A}, '{24'h0000C8, 24'h800000, 24'h0003E8},
         '{24'h000000, 24'h200000, 24'hFFFC18}, '{24'hFFFFFF, 24'h400000, 24'h7FFFFF},
         '{24'h000001, 24'h400000, 24'h800000}};
      for (int k = 0; k < 6; k++) begin
         ofs = tv[k][0];
         gn = tv[k][1];
         for (int b = 0; b < 3; b++) begin
            wr(8'h07 + 8'(b), ofs[8*b +: 8]);
            wr(8'h0A + 8'(b), gn[8*b +: 8]);
         end
         for (int b = 0; b < 3; b++) begin
            rd(8'h07 + 8'(b), ofs[8*b +: 8]);
            rd(8'h0A + 8'(b), gn[8*b +: 8]);
         end
         RAW_VALID <= 1'b1;
         RAW_DATA <= tv[k][2];
         exp_q.push_back(model(tv[k][2]));
         @(posedge CLK_SYS);
         RAW_DATA <= tv[k][2] ^ 24'h000002;
         exp_q.push_back(model(tv[k][2] ^ 24'h000002));
         @(posedge CLK_SYS);
         RAW_VALID <= 1'b0;
         repeat (5) @(posedge CLK_SYS);
         chk(24'(exp_q.size()), 24'h000000);
      end
      rd(8'h20, 8'h01);
      rd(8'h20, 8'h00);
   endtask

   // ----------------------------------------
   // Sequence and timeout
   // ----------------------------------------
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 2000) begin
         error_cnt++;
         summarize();
      end
   end

   initial begin
      repeat (2) @(posedge CLK_SYS);
      SRST <= 1'b0;
      t_reset();
      t_neighbours();
      t_ref();
      t_route();
      t_cal();
      summarize();
   end
endmodule

// ===== logic/cal_datapath.sv
// Offset subtraction then gain scaling with saturation
`timescale 1ns/1ps
module cal_datapath
   import cal_regs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Sample path
   cal_path_if.path cp
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [23:0] sat24(input logic signed [47:0] v, output logic clip);
      if (v > 48'sh0000_007F_FFFF) begin
         clip = 1'b1;
         sat24 = 24'h7FFFFF;
      end else if (v < -48'sh0000_0080_0000) begin
         clip = 1'b1;
         sat24 = 24'h800000;
      end else begin
         clip = 1'b0;
         sat24 = v[23:0];
      end
   endfunction

   logic               s1_valid_reg;
   logic signed [24:0] s1_diff_reg;
   logic               out_valid_reg;
   logic [23:0]        out_data_reg;
   logic               clip_reg;
   logic signed [49:0] product;
   logic signed [47:0] scaled;
   logic [23:0]        sat_val;
   logic               sat_clip;

   // ----------------------------------------
   // Stage 1: offset subtraction
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         s1_valid_reg <= 1'b0;
         s1_diff_reg  <= '0;
      end else begin
         s1_valid_reg <= cp.in_valid;
         s1_diff_reg  <= 25'($signed(cp.in_data)) - 25'($signed(cp.offset_word)); // R05 R06
      end
   end

   // ----------------------------------------
   // Stage 2: gain scaling
   // ----------------------------------------
   always_comb begin
      product = 50'(s1_diff_reg) * $signed({26'h0, cp.gain_word}); // R08 R09
      scaled  = 48'(product >>> GAIN_SHIFT);
      sat_val = sat24(scaled, sat_clip); // R14
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
         clip_reg      <= 1'b0;
      end else begin
         out_valid_reg <= s1_valid_reg;
         if (s1_valid_reg) begin
            out_data_reg <= sat_val;
            clip_reg     <= sat_clip;
         end
      end
   end

   assign cp.out_valid = out_valid_reg;
   assign cp.out_data  = out_data_reg;
   assign cp.clipped   = clip_reg;

endmodule

// ===== logic/cal_path_if.sv
// Interface carrying samples between register bank and calibration datapath
`timescale 1ns/1ps
interface cal_path_if;
   logic        in_valid;
   logic [23:0] in_data;
   logic [23:0] offset_word;
   logic [23:0] gain_word;
   logic        out_valid;
   logic [23:0] out_data;
   logic        clipped;

   modport bank (output in_valid, in_data, offset_word, gain_word, input out_valid, out_data, clipped);
   modport path (input in_valid, in_data, offset_word, gain_word, output out_valid, out_data, clipped);
endinterface

// ===== logic/cal_reg_bank.sv
// Reference, calibration and current routing register bank with calibration datapath
//
// Operation
// R01: Bit 4 of reference register drives internal reference enable, reset off.
// R02: Bits 3:2 pick positive reference: internal, supply, external zero, external two; code gives supply for external two when INPUT_COUNT < 10.
// R03: Bits 1:0 pick negative reference: internal, ground, external one, external three; code gives ground for external three when INPUT_COUNT < 10.
// R04: Offset word is 24 bits over bytes 07h-09h, LSB lowest, resets zero.
// R05: Offset word is read as signed two's complement.
// R06: Offset is subtracted from every raw result before gain correction.
// R07: Gain word is 24-bit unsigned at 0Ah-0Ch, resets to 400000h.
// R08: Offset-corrected data is multiplied by gain word over 400000h.
// R09: Gain scaling happens only after offset subtraction completes.
// R10: Current routing register at 0Dh resets to FFh, both sources disconnected.
// R11: Upper nibble routes second source: 0-9 inputs, Ah common, above unconnected; code leaves input codes at or above INPUT_COUNT unconnected.
// R12: Lower nibble routes first source with the same code table.
// R13: Reference register sits at 06h and resets to 05h.
// R14: Corrected result saturates to the signed 24-bit range instead of wrapping.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module cal_reg_bank
   import cal_regs_pkg::*;
#(
   parameter int INPUT_COUNT = 10
)
(
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   // Register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [7:0]  REG_RDATA,
   // Raw conversion input
   input  wire logic        RAW_VALID,
   input  wire logic [23:0] RAW_DATA,
   // Corrected conversion output
   output logic             CAL_VALID,
   output logic      [23:0] CAL_DATA,
   // Reference control
   output logic             INTERNAL_REF_ON,
   output logic      [1:0]  REF_POS_SELECT,
   output logic      [1:0]  REF_NEG_SELECT,
   // Current source routing, one-hot inputs plus common
   output logic      [9:0]  SRC1_INPUT_SEL,
   output logic             SRC1_COMMON_SEL,
   output logic      [9:0]  SRC2_INPUT_SEL,
   output logic             SRC2_COMMON_SEL
);

   // Elaboration check on the input count
   if (INPUT_COUNT < 1 || INPUT_COUNT > 10) begin
      $error("INPUT_COUNT must be 1 to 10");
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Decode a routing nibble into one-hot input selects
   function automatic logic [9:0] route_inputs(input logic [3:0] code);
      logic [9:0] r;
      r = '0;
      if (code <= ROUTE_LAST_INPUT && int'(code) < INPUT_COUNT) begin
         r[code] = 1'b1;
      end
      route_inputs = r;
   endfunction

   // Limit reference codes to what this variant supports
   function automatic logic [1:0] ref_code(input logic [1:0] code);
      if (code == REF_SEL_EXT_HIGH && INPUT_COUNT < 10) begin
         ref_code = REF_SEL_SUPPLY;
      end else begin
         ref_code = code;
      end
   endfunction

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [7:0]  reference_select_reg;
   logic [7:0]  offset_trim_reg [3];
   logic [7:0]  gain_trim_reg [3];
   logic [7:0]  current_routing_reg;
   logic [7:0]  rdata_reg;
   logic        clip_seen_reg;
   logic        cal_valid_reg;
   logic [23:0] cal_data_reg;
   logic        ref_on_reg;
   logic [1:0]  ref_pos_reg;
   logic [1:0]  ref_neg_reg;
   logic [9:0]  src1_in_reg;
   logic        src1_com_reg;
   logic [9:0]  src2_in_reg;
   logic        src2_com_reg;
   logic [7:0]  rdata_next;

   cal_path_if cp ();

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         reference_select_reg <= RST_REFERENCE_SELECT; // R13
      end else if (REG_WR && REG_ADDR == ADDR_REFERENCE_SELECT) begin
         reference_select_reg <= REG_WDATA & REF_WRITABLE_MASK;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         offset_trim_reg[0] <= RST_OFFSET_TRIM_B0; // R04
         offset_trim_reg[1] <= RST_OFFSET_TRIM_B1;
         offset_trim_reg[2] <= RST_OFFSET_TRIM_B2;
      end else if (REG_WR) begin
         if (REG_ADDR == ADDR_OFFSET_TRIM_B0) begin
            offset_trim_reg[0] <= REG_WDATA;
         end
         if (REG_ADDR == ADDR_OFFSET_TRIM_B1) begin
            offset_trim_reg[1] <= REG_WDATA;
         end
         if (REG_ADDR == ADDR_OFFSET_TRIM_B2) begin
            offset_trim_reg[2] <= REG_WDATA;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         gain_trim_reg[0] <= RST_GAIN_TRIM_B0; // R07
         gain_trim_reg[1] <= RST_GAIN_TRIM_B1;
         gain_trim_reg[2] <= RST_GAIN_TRIM_B2;
      end else if (REG_WR) begin
         if (REG_ADDR == ADDR_GAIN_TRIM_B0) begin
            gain_trim_reg[0] <= REG_WDATA;
         end
         if (REG_ADDR == ADDR_GAIN_TRIM_B1) begin
            gain_trim_reg[1] <= REG_WDATA;
         end
         if (REG_ADDR == ADDR_GAIN_TRIM_B2) begin
            gain_trim_reg[2] <= REG_WDATA;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         current_routing_reg <= RST_CURRENT_ROUTING; // R10
      end else if (REG_WR && REG_ADDR == ADDR_CURRENT_ROUTING) begin
         current_routing_reg <= REG_WDATA;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_comb begin
      rdata_next = 8'h00;
      unique case (REG_ADDR)
         ADDR_REFERENCE_SELECT: rdata_next = reference_select_reg;
         ADDR_OFFSET_TRIM_B0:   rdata_next = offset_trim_reg[0];
         ADDR_OFFSET_TRIM_B1:   rdata_next = offset_trim_reg[1];
         ADDR_OFFSET_TRIM_B2:   rdata_next = offset_trim_reg[2];
         ADDR_GAIN_TRIM_B0:     rdata_next = gain_trim_reg[0];
         ADDR_GAIN_TRIM_B1:     rdata_next = gain_trim_reg[1];
         ADDR_GAIN_TRIM_B2:     rdata_next = gain_trim_reg[2];
         ADDR_CURRENT_ROUTING:  rdata_next = current_routing_reg;
         ADDR_CAL_STATUS:       rdata_next = {7'h00, clip_seen_reg};
         default:               rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         rdata_reg <= 8'h00;
      end else if (REG_RD) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // ----------------------------------------
   // Saturation status, read clears, set wins
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         clip_seen_reg <= 1'b0;
      end else if (cp.out_valid && cp.clipped) begin
         clip_seen_reg <= 1'b1; // R14
      end else if (REG_RD && REG_ADDR == ADDR_CAL_STATUS) begin
         clip_seen_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Calibration datapath
   // ----------------------------------------
   assign cp.in_valid    = RAW_VALID;
   assign cp.in_data     = RAW_DATA;
   assign cp.offset_word = {offset_trim_reg[2], offset_trim_reg[1], offset_trim_reg[0]}; // R04 R05
   assign cp.gain_word   = {gain_trim_reg[2], gain_trim_reg[1], gain_trim_reg[0]}; // R07

   cal_datapath u_path (
      .clk  (CLK_SYS),
      .srst (SRST),
      .cp   (cp)
   );

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         cal_valid_reg <= 1'b0;
         cal_data_reg  <= '0;
      end else begin
         cal_valid_reg <= cp.out_valid;
         if (cp.out_valid) begin
            cal_data_reg <= cp.out_data; // R09
         end
      end
   end

   // ----------------------------------------
   // Reference control outputs
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ref_on_reg  <= 1'b0;
         ref_pos_reg <= REF_SEL_SUPPLY;
         ref_neg_reg <= REF_SEL_SUPPLY;
      end else begin
         ref_on_reg  <= reference_select_reg[REF_ON_BIT]; // R01
         ref_pos_reg <= ref_code(reference_select_reg[REF_POS_LSB +: 2]); // R02
         ref_neg_reg <= ref_code(reference_select_reg[REF_NEG_LSB +: 2]); // R03
      end
   end

   // ----------------------------------------
   // Current source routing outputs
   // ----------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         src1_in_reg  <= '0;
         src1_com_reg <= 1'b0;
         src2_in_reg  <= '0;
         src2_com_reg <= 1'b0;
      end else begin
         src1_in_reg  <= route_inputs(current_routing_reg[SRC1_ROUTE_LSB +: 4]); // R12
         src1_com_reg <= current_routing_reg[SRC1_ROUTE_LSB +: 4] == ROUTE_COMMON; // R12
         src2_in_reg  <= route_inputs(current_routing_reg[SRC2_ROUTE_LSB +: 4]); // R11
         src2_com_reg <= current_routing_reg[SRC2_ROUTE_LSB +: 4] == ROUTE_COMMON; // R11
      end
   end

   assign REG_RDATA       = rdata_reg;
   assign CAL_VALID       = cal_valid_reg;
   assign CAL_DATA        = cal_data_reg;
   assign INTERNAL_REF_ON = ref_on_reg;
   assign REF_POS_SELECT  = ref_pos_reg;
   assign REF_NEG_SELECT  = ref_neg_reg;
   assign SRC1_INPUT_SEL  = src1_in_reg;
   assign SRC1_COMMON_SEL = src1_com_reg;
   assign SRC2_INPUT_SEL  = src2_in_reg;
   assign SRC2_COMMON_SEL = src2_com_reg;

endmodule

// ===== logic/cal_regs_pkg.sv
// Package of register offsets, field positions, reset values and datapath constants
package cal_regs_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_REFERENCE_SELECT = 8'h06;
   localparam logic [7:0] ADDR_OFFSET_TRIM_B0   = 8'h07;
   localparam logic [7:0] ADDR_OFFSET_TRIM_B1   = 8'h08;
   localparam logic [7:0] ADDR_OFFSET_TRIM_B2   = 8'h09;
   localparam logic [7:0] ADDR_GAIN_TRIM_B0     = 8'h0A;
   localparam logic [7:0] ADDR_GAIN_TRIM_B1     = 8'h0B;
   localparam logic [7:0] ADDR_GAIN_TRIM_B2     = 8'h0C;
   localparam logic [7:0] ADDR_CURRENT_ROUTING  = 8'h0D;
   localparam logic [7:0] ADDR_CAL_STATUS       = 8'h20;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_REFERENCE_SELECT = 8'h05;
   localparam logic [7:0] RST_OFFSET_TRIM_B0   = 8'h00;
   localparam logic [7:0] RST_OFFSET_TRIM_B1   = 8'h00;
   localparam logic [7:0] RST_OFFSET_TRIM_B2   = 8'h00;
   localparam logic [7:0] RST_GAIN_TRIM_B0     = 8'h00;
   localparam logic [7:0] RST_GAIN_TRIM_B1     = 8'h00;
   localparam logic [7:0] RST_GAIN_TRIM_B2     = 8'h40;
   localparam logic [7:0] RST_CURRENT_ROUTING  = 8'hFF;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int REF_ON_BIT     = 4;
   localparam int REF_POS_LSB    = 2;
   localparam int REF_NEG_LSB    = 0;
   localparam int SRC2_ROUTE_LSB = 4;
   localparam int SRC1_ROUTE_LSB = 0;
   localparam logic [7:0] REF_WRITABLE_MASK = 8'h1F;

   // ----------------------------------------
   // Reference selector codes
   // ----------------------------------------
   localparam logic [1:0] REF_SEL_INTERNAL = 2'h0;
   localparam logic [1:0] REF_SEL_SUPPLY   = 2'h1;
   localparam logic [1:0] REF_SEL_EXT_LOW  = 2'h2;
   localparam logic [1:0] REF_SEL_EXT_HIGH = 2'h3;

   // ----------------------------------------
   // Current routing codes
   // ----------------------------------------
   localparam logic [3:0] ROUTE_LAST_INPUT = 4'h9;
   localparam logic [3:0] ROUTE_COMMON     = 4'hA;

   // ----------------------------------------
   // Datapath constants
   // ----------------------------------------
   localparam int DATA_W      = 24;
   localparam int GAIN_SHIFT  = 22;
   localparam int PIPE_STAGES = 2;

endpackage
